//--- counter_array_pkg.sv
// constants for the counter array block
// assumes a 32-bit apb bus, one aligned word per register index
package counter_array_pkg;
  // ==========================================
  // register indices, byte address = 4 * index
  localparam logic [9:0] IDX_MODE = 10'h0D9;
  localparam logic [9:0] IDX_CTRL = 10'h0D8;
  localparam logic [9:0] IDX_CNT_LO = 10'h040;
  localparam logic [9:0] IDX_CNT_HI = 10'h041;
  localparam logic [9:0] IDX_MMODE0 = 10'h020;
  localparam logic [9:0] IDX_CMPL0 = 10'h028;
  localparam logic [9:0] IDX_CMPH0 = 10'h030;
  // ==========================================
  // counter mode fields
  localparam int IDLE_STOP_BIT = 7;
  localparam int WD_EN_BIT = 6;
  localparam int SRC_HI_BIT = 2;
  localparam int SRC_LO_BIT = 1;
  localparam int OVF_IE_BIT = 0;
  localparam logic [7:0] MODE_USED = 8'hC7;
  // counter control fields
  localparam int OVF_FLAG_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam logic [7:0] CTRL_USED = 8'hDF;
  // module mode fields
  localparam int CMP_EN_BIT = 6;
  localparam int CAP_RISE_BIT = 5;
  localparam int CAP_FALL_BIT = 4;
  localparam int MATCH_EN_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PWM_BIT = 1;
  localparam int MOD_IE_BIT = 0;
  localparam logic [7:0] MMODE_USED = 8'h7F;
  // ==========================================
  // reset values and counts
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] DIV6_LAST = 3'h5;
  localparam int NUM_MODULES = 5;
  localparam int WD_MODULE = 4;
  typedef enum logic [1:0] {
    SRC_DIV6 = 2'h0,
    SRC_DIV2 = 2'h1,
    SRC_T0 = 2'h2,
    SRC_EXT = 2'h3
  } count_src_t;
endpackage

//--- cc_unit.sv
// one compare/capture module of the counter array
// assumes count and its update strobe come from the shared time base
`timescale 1ns/1ps
module cc_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // time base
  input wire logic [15:0] count,
  input wire logic upd,
  // register writes
  input wire logic mode_wr,
  input wire logic lo_wr,
  input wire logic hi_wr,
  input wire logic [7:0] wdata,
  // capture pin edges
  input wire logic pin_rise,
  input wire logic pin_fall,
  // results
  output logic [7:0] mode_r,
  output logic [7:0] cmp_lo_r,
  output logic [7:0] cmp_hi_r,
  output logic match,
  output logic event_pulse,
  output logic pin_out_r,
  output logic pin_drive
);
  logic cmp_en, pwm_en, cap_go, tog_go, reload;
  assign cmp_en = mode_r[counter_array_pkg::CMP_EN_BIT];
  assign pwm_en = cmp_en & mode_r[counter_array_pkg::PWM_BIT];
  // ==========================================
  // compare and capture
  assign match = upd & (count == {cmp_hi_r, cmp_lo_r});
  assign cap_go = (pin_rise & mode_r[counter_array_pkg::CAP_RISE_BIT])
    | (pin_fall & mode_r[counter_array_pkg::CAP_FALL_BIT]);
  assign tog_go = match & cmp_en & mode_r[counter_array_pkg::TOGGLE_BIT];
  assign event_pulse = cap_go
    | (match & cmp_en & mode_r[counter_array_pkg::MATCH_EN_BIT]);
  assign reload = pwm_en & upd & (count[7:0] == 8'h00);
  assign pin_drive = cmp_en & (pwm_en | mode_r[counter_array_pkg::TOGGLE_BIT]);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_r <= counter_array_pkg::REG_RST;
    end else if (mode_wr) begin
      mode_r <= wdata & counter_array_pkg::MMODE_USED;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmp_lo_r <= counter_array_pkg::REG_RST;
      cmp_hi_r <= counter_array_pkg::REG_RST;
    end else if (cap_go) begin
      cmp_lo_r <= count[7:0];
      cmp_hi_r <= count[15:8];
    end else begin
      if (lo_wr) begin
        cmp_lo_r <= wdata;
      end else if (reload) begin
        cmp_lo_r <= cmp_hi_r;
      end
      if (hi_wr) begin
        cmp_hi_r <= wdata;
      end
    end
  end

  // ==========================================
  // output pin level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_out_r <= 1'b0;
    end else if (pwm_en) begin
      pin_out_r <= (count[7:0] >= cmp_lo_r);
    end else if (tog_go) begin
      pin_out_r <= ~pin_out_r;
    end
  end

  // ==========================================
  // checks
  sequence cap_seq;
    cap_go ##0 !lo_wr;
  endsequence
  capture_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    cap_seq |=> cmp_lo_r == $past(count[7:0]) && cmp_hi_r == $past(count[15:8]))
    else $error("capture did not load count");
  toggle_match_a: assert property (@(posedge clk_sys) disable iff (reset)
    tog_go && !pwm_en |=> pin_out_r != $past(pin_out_r))
    else $error("output did not toggle on match");
  pwm_level_a: assert property (@(posedge clk_sys) disable iff (reset)
    pwm_en && count[7:0] < cmp_lo_r |=> !pin_out_r)
    else $error("pwm output high below duty");
  match_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    match && !cap_go && !mode_r[counter_array_pkg::MATCH_EN_BIT] |-> !event_pulse)
    else $error("match raised event without match enable");
endmodule // cc_unit

//--- counter_array.sv
// counter array: shared 16-bit time base and five compare/capture modules
// assumes apb master on clk_sys; port 1 pins arrive unsynchronised
//
// Contract
// - time base advances from clock/6, clock/2, timer0 overflow or external pin.
// - source field 00 div6, 01 div2, 10 timer0, 11 external pin.
// - one 16-bit count is the time base for all five modules.
// - idle-stop bit set halts the count while the cpu idles.
// - watchdog enable turns module 4 watchdog on; module stays usable otherwise.
// - enabled watchdog match on module 4 makes an internal reset pulse.
// - run bit gates the counter; cleared means stopped.
// - overflow sets sticky flag; interrupt if enabled; only software clears it.
// - module match or capture sets its flag; software can clear each.
// - overflow and five module events share one interrupt line.
// - external count on p1 bit 2, modules on bits 3-7; else gpio.
// - module interrupt enable gates its flag onto the interrupt line.
// - toggle bit makes the module pin invert on each compare match.
// - match enable lets a compare match set the module flag.
// - falling and rising enables select capture edges; both means either.
// - comparator enable activates compare; needed by timer, output, pwm.
// - capture edge copies the 16-bit count to capture registers, sets flag.
// - comparator plus match enable make a 16-bit software timer.
// - toggle, match and comparator enable make high-speed output mode.
// - pwm bit selects 8-bit pwm sharing the time base frequency.
// - pwm low while count low byte below compare; reload on wrap.
`timescale 1ns/1ps
module counter_array (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic cpu_idle,
  input wire logic timer0_ovf,
  output logic irq,
  output logic wd_reset,
  // port 1 pins, bits 2 to 7
  input wire logic [7:2] p1_in,
  input wire logic [7:2] gpio_out,
  input wire logic [7:2] gpio_oe,
  output logic [7:2] p1_out,
  output logic [7:2] p1_oe
);
  localparam int N = counter_array_pkg::NUM_MODULES;

  function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
    hit = (idx == want);
  endfunction

  // ==========================================
  // apb decode
  logic [9:0] idx;
  logic setup, wr;
  logic [N-1:0] mm_wr, lo_wr, hi_wr;
  logic mode_wr, ctrl_wr, cnt_lo_wr, cnt_hi_wr;
  logic [31:0] rd_nxt;
  logic mapped;

  assign idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign mode_wr = wr & hit(idx, counter_array_pkg::IDX_MODE);
  assign ctrl_wr = wr & hit(idx, counter_array_pkg::IDX_CTRL);
  assign cnt_lo_wr = wr & hit(idx, counter_array_pkg::IDX_CNT_LO);
  assign cnt_hi_wr = wr & hit(idx, counter_array_pkg::IDX_CNT_HI);

  // ==========================================
  // registers
  logic [7:0] mode_r, ctrl_r;
  logic [15:0] count_r;
  logic [2:0] pre_r;
  logic upd_r;
  logic [N-1:0] flag_r;
  logic ovf_flag_r;
  logic wd_reset_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // ==========================================
  // per-module signals
  logic [7:0] m_mode [N];
  logic [7:0] m_lo [N];
  logic [7:0] m_hi [N];
  logic [N-1:0] m_match, m_event, m_out, m_drive, m_ie;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(idx, counter_array_pkg::IDX_MODE)) begin
      rd_nxt[7:0] = mode_r;
    end else if (hit(idx, counter_array_pkg::IDX_CTRL)) begin
      rd_nxt[7:0] = {ovf_flag_r, ctrl_r[6], 1'b0, flag_r};
    end else if (hit(idx, counter_array_pkg::IDX_CNT_LO)) begin
      rd_nxt[7:0] = count_r[7:0];
    end else if (hit(idx, counter_array_pkg::IDX_CNT_HI)) begin
      rd_nxt[7:0] = count_r[15:8];
    end else begin
      mapped = 1'b0;
      for (int i = 0; i < N; i++) begin
        if (hit(idx, counter_array_pkg::IDX_MMODE0 + 10'(i))) begin
          rd_nxt[7:0] = m_mode[i];
          mapped = 1'b1;
        end
        if (hit(idx, counter_array_pkg::IDX_CMPL0 + 10'(i))) begin
          rd_nxt[7:0] = m_lo[i];
          mapped = 1'b1;
        end
        if (hit(idx, counter_array_pkg::IDX_CMPH0 + 10'(i))) begin
          rd_nxt[7:0] = m_hi[i];
          mapped = 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      mm_wr[i] = wr & hit(idx, counter_array_pkg::IDX_MMODE0 + 10'(i));
      lo_wr[i] = wr & hit(idx, counter_array_pkg::IDX_CMPL0 + 10'(i));
      hi_wr[i] = wr & hit(idx, counter_array_pkg::IDX_CMPH0 + 10'(i));
    end
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= ~mapped;
    end
  end
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_r <= counter_array_pkg::REG_RST;
    end else if (mode_wr) begin
      mode_r <= pwdata[7:0] & counter_array_pkg::MODE_USED;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= counter_array_pkg::REG_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= pwdata[7:0] & counter_array_pkg::CTRL_USED;
    end
  end

  // ==========================================
  // pin synchronisers, three stages
  logic [7:2] s1_r, s2_r, s3_r, filt_r, filt_d_r;
  logic [7:2] rise, fall;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      s3_r <= 6'h00;
      filt_r <= 6'h00;
      filt_d_r <= 6'h00;
    end else begin
      s1_r <= p1_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int b = 2; b < 8; b++) begin
        if (s2_r[b] == s3_r[b]) begin
          filt_r[b] <= s3_r[b];
        end
      end
      filt_d_r <= filt_r;
    end
  end
  assign rise = filt_r & ~filt_d_r;
  assign fall = ~filt_r & filt_d_r;

  // ==========================================
  // time base
  counter_array_pkg::count_src_t src;
  logic src_tick, run_ok, adv, ovf_set;

  assign src = counter_array_pkg::count_src_t'({mode_r[counter_array_pkg::SRC_HI_BIT],
    mode_r[counter_array_pkg::SRC_LO_BIT]});

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pre_r <= 3'h0;
    end else if (pre_r == counter_array_pkg::DIV6_LAST) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  always_comb begin
    unique case (src)
      counter_array_pkg::SRC_DIV6: src_tick = (pre_r == counter_array_pkg::DIV6_LAST);
      counter_array_pkg::SRC_DIV2: src_tick = pre_r[0];
      counter_array_pkg::SRC_T0: src_tick = timer0_ovf;
      counter_array_pkg::SRC_EXT: src_tick = rise[2];
    endcase
  end

  assign run_ok = ctrl_r[counter_array_pkg::RUN_BIT]
    & ~(mode_r[counter_array_pkg::IDLE_STOP_BIT] & cpu_idle);
  assign adv = run_ok & src_tick;
  assign ovf_set = adv & (count_r == counter_array_pkg::CNT_MAX);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_r <= 16'h0000;
    end else if (cnt_lo_wr) begin
      count_r[7:0] <= pwdata[7:0];
    end else if (cnt_hi_wr) begin
      count_r[15:8] <= pwdata[7:0];
    end else if (adv) begin
      count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= adv & ~cnt_lo_wr & ~cnt_hi_wr;
    end
  end

  // ==========================================
  // flags, hardware set wins over software write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_r <= 1'b1;
    end else if (ctrl_wr) begin
      ovf_flag_r <= pwdata[counter_array_pkg::OVF_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_r <= 5'h00;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (m_event[i]) begin
          flag_r[i] <= 1'b1;
        end else if (ctrl_wr) begin
          flag_r[i] <= pwdata[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      m_ie[i] = m_mode[i][counter_array_pkg::MOD_IE_BIT];
    end
  end
  assign irq = (ovf_flag_r & mode_r[counter_array_pkg::OVF_IE_BIT])
    | (|(flag_r & m_ie));

  // ==========================================
  // watchdog on module 4
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wd_reset_r <= 1'b0;
    end else begin
      wd_reset_r <= mode_r[counter_array_pkg::WD_EN_BIT]
        & m_match[counter_array_pkg::WD_MODULE];
    end
  end
  assign wd_reset = wd_reset_r;

  // ==========================================
  // compare/capture modules
  for (genvar g = 0; g < N; g++) begin : g_mod
    cc_unit u_cc (
      .clk_sys(clk_sys),
      .reset(reset),
      .count(count_r),
      .upd(upd_r),
      .mode_wr(mm_wr[g]),
      .lo_wr(lo_wr[g]),
      .hi_wr(hi_wr[g]),
      .wdata(pwdata[7:0]),
      .pin_rise(rise[g+3]),
      .pin_fall(fall[g+3]),
      .mode_r(m_mode[g]),
      .cmp_lo_r(m_lo[g]),
      .cmp_hi_r(m_hi[g]),
      .match(m_match[g]),
      .event_pulse(m_event[g]),
      .pin_out_r(m_out[g]),
      .pin_drive(m_drive[g])
    );
  end

  // ==========================================
  // port 1 pin sharing
  always_comb begin
    p1_out[2] = gpio_out[2];
    p1_oe[2] = gpio_oe[2];
    for (int i = 0; i < N; i++) begin
      p1_out[i+3] = m_drive[i] ? m_out[i] : gpio_out[i+3];
      p1_oe[i+3] = m_drive[i] | gpio_oe[i+3];
    end
  end

  // ==========================================
  // checks
  sequence wrap_seq;
    adv ##0 count_r == counter_array_pkg::CNT_MAX ##0 !cnt_lo_wr ##0 !cnt_hi_wr;
  endsequence
  sequence no_cnt_wr;
    !cnt_lo_wr && !cnt_hi_wr;
  endsequence
  overflow_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
    wrap_seq |=> count_r == 16'h0000 && ovf_flag_r)
    else $error("overflow did not wrap and flag");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
    ovf_flag_r && !ctrl_wr |=> ovf_flag_r)
    else $error("overflow flag cleared by hardware");
  run_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!ctrl_r[counter_array_pkg::RUN_BIT] and no_cnt_wr) |=> $stable(count_r))
    else $error("counter moved while stopped");
  idle_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r[counter_array_pkg::IDLE_STOP_BIT] && cpu_idle && !cnt_lo_wr && !cnt_hi_wr
    |=> $stable(count_r))
    else $error("counter moved in idle");
  div6_rate_a: assert property (@(posedge clk_sys) disable iff (reset)
    adv && src == counter_array_pkg::SRC_DIV6 && !mode_wr
    |=> (!adv || src != counter_array_pkg::SRC_DIV6)[*5])
    else $error("div6 source too fast");
  irq_event_a: assert property (@(posedge clk_sys) disable iff (reset)
    m_event[0] && m_ie[0] && !mm_wr[0] |=> irq)
    else $error("module event with enable gave no interrupt");
  watchdog_a: assert property (@(posedge clk_sys) disable iff (reset)
    mode_r[counter_array_pkg::WD_EN_BIT] && m_match[counter_array_pkg::WD_MODULE]
    |=> wd_reset ##1 !wd_reset || $past(m_match[counter_array_pkg::WD_MODULE], 1))
    else $error("watchdog match gave no reset");
  event_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    |m_event |=> (flag_r & $past(m_event)) == $past(m_event))
    else $error("module event did not set flag");
endmodule // counter_array

//--- pin_partner.sv
// port 1 pin model facing the counter array
// assumes pins that nobody drives are pulled high
`timescale 1ns/1ps
module pin_partner #(
  parameter int WATCH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // device side
  input wire logic [7:2] p1_out,
  input wire logic [7:2] p1_oe,
  output logic [7:2] p1_in,
  // bench control
  input wire logic [7:2] drv_en,
  input wire logic [7:2] drv_val,
  output logic [7:0] edges_r
);
  logic oe_q;
  logic out_q;
  // ==========================================
  // wire level from all drivers
  always_comb begin
    for (int i = 2; i < 8; i++) begin
      p1_in[i] = p1_oe[i] ? p1_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
  // ==========================================
  // level changes of the watched driven pin
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oe_q <= 1'b0;
      out_q <= 1'b0;
      edges_r <= 8'h00;
    end
    else begin
      oe_q <= p1_oe[WATCH];
      out_q <= p1_out[WATCH];
      if (p1_oe[WATCH] && oe_q && (p1_out[WATCH] != out_q)) begin
        edges_r <= edges_r + 8'h01;
      end
    end
  end
endmodule // pin_partner

//--- counter_array_test.sv
// self-checking bench for the counter array
// assumes apb master on clk_sys and the pin model on port 1
`timescale 1ns/1ps
module counter_array_test;
  localparam logic [11:0] A_MODE = {counter_array_pkg::IDX_MODE, 2'b00};
  localparam logic [11:0] A_CTRL = {counter_array_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CLO = {counter_array_pkg::IDX_CNT_LO, 2'b00};
  localparam logic [11:0] A_CHI = {counter_array_pkg::IDX_CNT_HI, 2'b00};
  localparam logic [7:0] MM [5] = '{8'h49, 8'h44, 8'h40, 8'h48, 8'h48};
  localparam logic [7:0] CAPS [3] = '{8'h20, 8'h10, 8'h30};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, cpu_idle, timer0_ovf, pready, pslverr, irq, wd_reset, err, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] seed = 32'h00006F03;
  logic [7:2] p1_in, gpio_out, gpio_oe, p1_out, p1_oe, drv_en, drv_val;
  logic [7:0] edges_r, d, cm;
  logic [15:0] rd, rd2, ex;
  int fail_count = 0;
  int n_compared = 0;
  int wd_cnt = 0;
  int n, h;
  // ==========================================
  // clock, design and pins
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wd_reset === 1'b1) wd_cnt++;
  counter_array dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf), .irq(irq),
    .wd_reset(wd_reset), .p1_in(p1_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .p1_out(p1_out), .p1_oe(p1_oe));
  pin_partner #(.WATCH(4)) pins_u (.clk_sys(clk_sys), .reset(reset), .p1_out(p1_out),
    .p1_oe(p1_oe), .p1_in(p1_in), .drv_en(drv_en), .drv_val(drv_val), .edges_r(edges_r));
  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] ra(input logic [9:0] base, input int m);
    return {base + 10'(m), 2'b00};
  endfunction
  function automatic logic [15:0] in_rng(input int v, input int e, input int t);
    return (v >= e - t && v <= e + t) ? 16'h0001 : 16'h0000;
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at time %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] wd,
                     output logic [15:0] q, output logic e);
    int c;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (c == 50) fail_count++;
    q = {8'h00, prdata[7:0]};
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] wd);
    logic [15:0] q;
    logic e;
    apb(a, 1'b1, wd, q, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    logic x;
    apb(a, 1'b0, 8'h00, q, x);
    chk(q, e);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, cpu_idle, timer0_ovf} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    gpio_out = 6'h2A;
    gpio_oe = 6'h15;
    drv_en = 6'h09;
    drv_val = 6'h00;
    ex = 16'h0000;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    r = rnd();
    gpio_out <= r[5:0];
    gpio_oe <= r[11:6] & 6'h32;
    tick(2);
    chk(16'(p1_out), 16'(gpio_out));
    chk(16'(p1_oe), 16'(gpio_oe));
    rdc(A_MODE, 16'h0000);
    rdc(A_CTRL, 16'h0000);
    rdc(A_CLO, 16'h0000);
    rdc(ra(counter_array_pkg::IDX_MMODE0, 4), 16'h0000);
    apb(12'h000, 1'b0, 8'h00, rd, err);
    chk(16'(err), 16'h0001);
    chk(rd, 16'h0000);
    wr(A_MODE, r[7:0]);
    rdc(A_MODE, 16'(r[7:0] & counter_array_pkg::MODE_USED));
    wr(A_MODE, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(A_MODE, 8'(s << 1));
      wr(A_CLO, 8'h00);
      wr(A_CHI, 8'h00);
      n = 1 + int'(rnd() % 32'd20);
      wr(A_CTRL, 8'h40);
      if (s < 2) tick(60);
      else for (int i = 0; i < n; i++) begin
        if (s == 2) begin
          timer0_ovf <= 1'b1;
          tick(1);
          timer0_ovf <= 1'b0;
          tick(3);
        end
        else begin
          drv_val[2] <= 1'b1;
          tick(6);
          drv_val[2] <= 1'b0;
          tick(6);
        end
      end
      tick(8);
      wr(A_CTRL, 8'h00);
      apb(A_CLO, 1'b0, 8'h00, rd, err);
      chk(in_rng(int'(rd), s == 0 ? 12 : s == 1 ? 35 : n, s < 2 ? 3 : 0), 16'h0001);
    end
    wr(A_MODE, 8'h82);
    wr(A_CTRL, 8'h40);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wr(A_MODE, 8'h02);
      cpu_idle <= (k != 1);
      tick(4);
      apb(A_CLO, 1'b0, 8'h00, rd, err);
      tick(20);
      apb(A_CLO, 1'b0, 8'h00, rd2, err);
      chk(16'(rd2 !== rd), k == 0 ? 16'h0000 : 16'h0001);
    end
    cpu_idle <= 1'b0;
    wr(A_CTRL, 8'h00);
    apb(A_CLO, 1'b0, 8'h00, rd, err);
    tick(20);
    apb(A_CLO, 1'b0, 8'h00, rd2, err);
    chk(rd2, rd);
    wr(A_MODE, 8'h03);
    wr(A_CLO, 8'hFE);
    wr(A_CHI, 8'hFF);
    wr(A_CTRL, 8'h40);
    tick(20);
    rdc(A_CTRL, 16'h00C0);
    rdc(A_CHI, 16'h0000);
    chk(16'(irq), 16'h0001);
    wr(A_MODE, 8'h02);
    tick(1);
    chk(16'(irq), 16'h0000);
    rdc(A_CTRL, 16'h00C0);
    wr(A_CTRL, 8'h00);
    rdc(A_CTRL, 16'h0000);
    wr(A_MODE, 8'h42);
    for (int m = 0; m < 5; m++) begin
      wr(ra(counter_array_pkg::IDX_CMPL0, m), 8'(16 + 8 * m));
      wr(ra(counter_array_pkg::IDX_CMPH0, m), 8'h00);
      wr(ra(counter_array_pkg::IDX_MMODE0, m), MM[m]);
    end
    wr(A_CLO, 8'h00);
    wr(A_CHI, 8'h00);
    wr(A_CTRL, 8'h40);
    tick(150);
    rdc(A_CTRL, 16'h0059);
    chk(16'(edges_r), 16'h0001);
    chk(16'(p1_oe), 16'(gpio_oe | 6'h04));
    chk(16'(wd_cnt), 16'h0001);
    chk(16'(irq), 16'h0001);
    wr(ra(counter_array_pkg::IDX_MMODE0, 0), 8'h48);
    tick(1);
    chk(16'(irq), 16'h0000);
    rdc(A_CTRL, 16'h0059);
    wr(A_CTRL, 8'h40);
    rdc(A_CTRL, 16'h0040);
    wr(A_CTRL, 8'h00);
    for (int m = 0; m < 5; m++) wr(ra(counter_array_pkg::IDX_MMODE0, m), 8'h00);
    wr(ra(counter_array_pkg::IDX_CMPL0, 2), 8'h00);
    wr(ra(counter_array_pkg::IDX_CMPH0, 2), 8'h00);
    for (int k = 0; k < 6; k++) begin
      cm = CAPS[k / 2];
      wr(ra(counter_array_pkg::IDX_MMODE0, 2), cm);
      r = rnd();
      wr(A_CLO, r[7:0]);
      wr(A_CHI, r[15:8]);
      wr(A_CTRL, 8'h00);
      drv_val[5] <= ~drv_val[5];
      tick(10);
      hit = drv_val[5] ? cm[counter_array_pkg::CAP_RISE_BIT] : cm[counter_array_pkg::CAP_FALL_BIT];
      if (hit) ex = r[15:0];
      rdc(ra(counter_array_pkg::IDX_CMPL0, 2), 16'(ex[7:0]));
      rdc(ra(counter_array_pkg::IDX_CMPH0, 2), 16'(ex[15:8]));
      rdc(A_CTRL, hit ? 16'h0004 : 16'h0000);
    end
    r = rnd();
    d = 8'(32 + int'(r % 32'd192));
    wr(ra(counter_array_pkg::IDX_CMPL0, 3), d);
    wr(ra(counter_array_pkg::IDX_CMPH0, 3), d);
    wr(ra(counter_array_pkg::IDX_MMODE0, 3), 8'h42);
    wr(A_MODE, 8'h02);
    wr(A_CLO, 8'h00);
    wr(A_CTRL, 8'h40);
    tick(600);
    h = 0;
    repeat (512) begin
      @(posedge clk_sys);
      if (p1_out[6] === 1'b1) h++;
    end
    chk(in_rng(h, 2 * (256 - int'(d)), 6), 16'h0001);
    report_and_stop();
  end
endmodule // counter_array_test
